// [design/pec_pkg.sv]
/*
  Constants, types and helpers for the port error classifier.
  Assumes a single core clock domain and no software-visible registers.
*/
package pec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 64;
  localparam int BDF_W   = 16;
  localparam int BUS_W   = 8;
  localparam int FUNC_W  = 3;

  // ----------------------------------------------------------------
  // Error kinds, index of severity bit and reset values
  // ----------------------------------------------------------------
  localparam int SEV_DLP      = 0;
  localparam int SEV_SURPRISE = 1;
  localparam int SEV_POISON   = 2;
  localparam int SEV_ECRC     = 3;
  localparam int SEV_UR       = 4;
  localparam int SEV_ACS      = 5;
  localparam int SEV_W        = 6;
  localparam logic [5:0] SEV_RST = 6'h00;

  localparam logic [2:0] FUNC_ZERO = 3'h0;
  localparam logic [2:0] CPL_UR    = 3'h1;
  localparam logic [2:0] CPL_CA    = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ROUTE_ADDR, ROUTE_ID, ROUTE_IMPLICIT} pec_route_t;

  typedef enum {ST_IDLE, ST_REPORT} pec_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_window(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction : in_window

endpackage : pec_pkg

// [design/pec_claim.sv]
/*
  Claim decision of the bridge function for one received TLP.
  Assumes window and bus registers are stable while a TLP is presented.
*/
module pec_claim
(
  // Packet
  input  wire logic                       secondary_side,
  input  wire pec_pkg::pec_route_t        route,
  input  wire logic [pec_pkg::ADDR_W-1:0] addr,
  input  wire logic [pec_pkg::BDF_W-1:0]  dest_id,
  // Bridge setup
  input  wire logic [pec_pkg::ADDR_W-1:0] win0_base,
  input  wire logic [pec_pkg::ADDR_W-1:0] win0_limit,
  input  wire logic [pec_pkg::ADDR_W-1:0] win1_base,
  input  wire logic [pec_pkg::ADDR_W-1:0] win1_limit,
  input  wire logic [pec_pkg::BUS_W-1:0]  sec_bus,
  input  wire logic [pec_pkg::BUS_W-1:0]  sub_bus,
  input  wire logic [pec_pkg::BDF_W-1:0]  own_bdf,
  // Result
  output logic                            claimed
);

  logic [pec_pkg::BUS_W-1:0] bus;

  always_comb
  begin
    bus = dest_id[15:8];
    claimed = 1'b0;
    case (route)
      pec_pkg::ROUTE_ADDR:
        claimed = secondary_side ||
                  pec_pkg::in_window(addr, win0_base, win0_limit) ||
                  pec_pkg::in_window(addr, win1_base, win1_limit);
      pec_pkg::ROUTE_ID:
        claimed = secondary_side || (dest_id == own_bdf) ||
                  ((bus >= sec_bus) && (bus <= sub_bus));
      pec_pkg::ROUTE_IMPLICIT:
        claimed = 1'b1;
      default:
        claimed = 1'b0;
    endcase
  end

endmodule : pec_claim

// [design/pec_severity.sv]
/*
  Advisory versus fatal decision for one transaction-layer error.
  Assumes severity bit 1 means fatal, 0 means nonfatal.
*/
module pec_severity
(
  // Inputs
  input  wire logic sev_fatal,
  input  wire logic role_ok,
  // Result
  output logic      advisory,
  output logic      fatal
);

  always_comb
  begin
    advisory = !sev_fatal && role_ok;
    fatal    = sev_fatal;
  end

endmodule : pec_severity

// [design/pec_port_error_classifier.sv]
/*
  Per-port error classifier: sorts link, data-link and transaction
  faults into correctable or uncorrectable processing, decides claim,
  drop, forward and header logging, and requests UR completions.
  Assumes all inputs are synchronous to core_clk, one packet per cycle,
  and the port's own detectors supply the raw fault strobes.
*/
// Notes on behaviour
// - This port checks and handles its errors alone, regardless of other ports.
// - Address TLP claimed on primary inside windows, always on secondary.
// - ID TLP claimed on primary if in bus range or own ID; secondary always.
// - Implicitly routed TLPs are always claimed.
// - Receive link faults go to correctable processing.
// - Physical framing violations go to correctable processing.
// - Physical and link-layer errors are reported against all functions.
// - Link-layer errors dropped when physical layer already flagged packet.
// - Bad TLP is discarded and handled as correctable.
// - DLLP with failed LCRC is discarded and handled as correctable.
// - ACK or NAK with stray sequence number: discard, uncorrectable.
// - Surprise link loss triggers uncorrectable processing.
// - Transaction errors dropped when lower layers already flagged packet.
// - Poisoned TLP sets parity flag of the arrival side's status.
// - Poison advisory when nonfatal and from link or ultimate receiver.
// - Poison logs header; forward unless ultimate receiver, then drop.
// - ECRC error logs header; advisory only nonfatal intermediate from link.
// - Non-posted UR gets UR completion, always from function 0.
// - Bridge originates no requests; no completion time-out logic.
// - Completer abort only for access violations, logged as access error.
// - ECRC checked on TLPs with digest when any function enables it.
module pec_port_error_classifier #(
  parameter int NUM_FUNC = 1
)
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // Physical layer faults
  input  wire logic                       phy_link_err,
  input  wire logic                       phy_frame_err,
  input  wire logic                       phy_pkt_err,
  // Data-link layer faults
  input  wire logic                       dll_bad_tlp,
  input  wire logic                       dll_bad_dllp,
  input  wire logic                       dll_replay_tmo,
  input  wire logic                       dll_replay_roll,
  input  wire logic                       dll_ack_seq_err,
  input  wire logic                       dll_surprise_down,
  // Received TLP
  input  wire logic                       tlp_valid,
  input  wire logic                       tlp_secondary,
  input  wire pec_pkg::pec_route_t        tlp_route,
  input  wire logic [pec_pkg::ADDR_W-1:0] tlp_addr,
  input  wire logic [pec_pkg::BDF_W-1:0]  tlp_dest_id,
  input  wire logic                       tlp_from_link,
  input  wire logic                       tlp_ultimate,
  input  wire logic                       tlp_poisoned,
  input  wire logic                       tlp_digest,
  input  wire logic                       tlp_ecrc_bad,
  input  wire logic                       tlp_unsupported,
  input  wire logic                       tlp_non_posted,
  input  wire logic                       tlp_acs_violation,
  input  wire logic [NUM_FUNC-1:0]        func_ecrc_en,
  // Bridge setup
  input  wire logic [pec_pkg::ADDR_W-1:0] win0_base,
  input  wire logic [pec_pkg::ADDR_W-1:0] win0_limit,
  input  wire logic [pec_pkg::ADDR_W-1:0] win1_base,
  input  wire logic [pec_pkg::ADDR_W-1:0] win1_limit,
  input  wire logic [pec_pkg::BUS_W-1:0]  sec_bus,
  input  wire logic [pec_pkg::BUS_W-1:0]  sub_bus,
  input  wire logic [pec_pkg::BDF_W-1:0]  own_bdf,
  input  wire logic [pec_pkg::SEV_W-1:0]  uncorrectable_severity_register,
  input  wire logic                       parity_flag_clr_pri,
  input  wire logic                       parity_flag_clr_sec,
  // Processing results
  output logic                            corr_err,
  output logic                            uncorr_nonfatal,
  output logic                            uncorr_fatal,
  output logic                            all_functions,
  output logic                            acs_err,
  output logic                            tlp_claimed,
  output logic                            tlp_discard,
  output logic                            tlp_forward,
  output logic                            hdr_log,
  output logic                            cpl_gen,
  output logic [2:0]                      cpl_status,
  output logic [pec_pkg::FUNC_W-1:0]      cpl_func,
  output logic                            parity_detected_flag_pri,
  output logic                            parity_detected_flag_sec
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Claim and severity
  // ----------------------------------------------------------------
  logic claim_w;
  logic poi_adv;
  logic poi_fat;
  logic ecrc_adv;
  logic ecrc_fat;
  logic ur_adv;
  logic ur_fat;
  logic ecrc_active;

  pec_claim u_claim (
    .secondary_side (tlp_secondary),
    .route          (tlp_route),
    .addr           (tlp_addr),
    .dest_id        (tlp_dest_id),
    .win0_base      (win0_base),
    .win0_limit     (win0_limit),
    .win1_base      (win1_base),
    .win1_limit     (win1_limit),
    .sec_bus        (sec_bus),
    .sub_bus        (sub_bus),
    .own_bdf        (own_bdf),
    .claimed        (claim_w)
  );

  pec_severity u_sev_poison (
    .sev_fatal (uncorrectable_severity_register[pec_pkg::SEV_POISON]),
    .role_ok   (tlp_from_link || tlp_ultimate),
    .advisory  (poi_adv),
    .fatal     (poi_fat)
  );

  pec_severity u_sev_ecrc (
    .sev_fatal (uncorrectable_severity_register[pec_pkg::SEV_ECRC]),
    .role_ok   (!tlp_ultimate && tlp_from_link),
    .advisory  (ecrc_adv),
    .fatal     (ecrc_fat)
  );

  pec_severity u_sev_ur (
    .sev_fatal (uncorrectable_severity_register[pec_pkg::SEV_UR]),
    .role_ok   (tlp_non_posted),
    .advisory  (ur_adv),
    .fatal     (ur_fat)
  );

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  // State kept only for this port; no cross-port inputs exist.
  logic       corr_d, unf_d, fat_d, allf_d, acs_d;
  logic       clm_d, disc_d, fwd_d, log_d, cpl_d;
  logic [2:0] cst_d;
  logic [pec_pkg::FUNC_W-1:0] cfn_d;
  logic       dpp_d, dps_d;
  logic       corr_q, unf_q, fat_q, allf_q, acs_q;
  logic       clm_q, disc_q, fwd_q, log_q, cpl_q;
  logic [2:0] cst_q;
  logic [pec_pkg::FUNC_W-1:0] cfn_q;
  logic       dpp_q, dps_q;
  logic       dll_ok;
  logic       tl_ok;
  logic       poi_ev;
  logic       ecrc_ev;
  logic       ur_ev;
  logic       dlp_fat;
  logic       sd_fat;

  always_comb
  begin
    ecrc_active = |func_ecrc_en;
    dll_ok  = !phy_pkt_err;
    tl_ok   = tlp_valid && !phy_pkt_err && !dll_bad_tlp;
    poi_ev  = tl_ok && tlp_poisoned;
    ecrc_ev = tl_ok && ecrc_active && tlp_digest && tlp_ecrc_bad;
    ur_ev   = tl_ok && tlp_unsupported;
    dlp_fat = uncorrectable_severity_register[pec_pkg::SEV_DLP];
    sd_fat  = uncorrectable_severity_register[pec_pkg::SEV_SURPRISE];
    // Lower layers: correctable vs uncorrectable, all functions.
    corr_d = phy_link_err || phy_frame_err;
    corr_d = corr_d || (dll_ok && (dll_bad_tlp || dll_bad_dllp));
    corr_d = corr_d || dll_replay_tmo || dll_replay_roll;
    unf_d  = (dll_ok && dll_ack_seq_err && !dlp_fat) ||
             (dll_surprise_down && !sd_fat);
    fat_d  = (dll_ok && dll_ack_seq_err && dlp_fat) ||
             (dll_surprise_down && sd_fat);
    allf_d = corr_d || unf_d || fat_d;
    // Transaction layer
    corr_d = corr_d || (poi_ev && poi_adv) || (ecrc_ev && ecrc_adv)
             || (ur_ev && ur_adv);
    unf_d  = unf_d || (poi_ev && !poi_adv && !poi_fat)
             || (ecrc_ev && !ecrc_adv && !ecrc_fat)
             || (ur_ev && !ur_adv && !ur_fat);
    fat_d  = fat_d || (poi_ev && !poi_adv && poi_fat)
             || (ecrc_ev && !ecrc_adv && ecrc_fat)
             || (ur_ev && !ur_adv && ur_fat);
    acs_d  = tl_ok && tlp_acs_violation;
    clm_d  = tlp_valid && claim_w;
    // Bad TLPs never reach the transaction layer; they are discarded.
    disc_d = (tlp_valid && !tl_ok) ||
             ((poi_ev || ecrc_ev) && tlp_ultimate) || ur_ev || acs_d;
    fwd_d  = tl_ok && !disc_d;
    log_d  = poi_ev || ecrc_ev || ur_ev;
    // No completion time-out: this bridge never issues requests.
    cpl_d  = (ur_ev && tlp_non_posted) || acs_d;
    cst_d  = acs_d ? pec_pkg::CPL_CA : pec_pkg::CPL_UR;
    cfn_d  = pec_pkg::FUNC_ZERO;
    // Set wins over clear.
    dpp_d  = (poi_ev && !tlp_secondary) ||
             (dpp_q && !parity_flag_clr_pri);
    dps_d  = (poi_ev && tlp_secondary) ||
             (dps_q && !parity_flag_clr_sec);
  end

  always_ff @(posedge core_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      corr_q <= 1'b0;
      unf_q  <= 1'b0;
      fat_q  <= 1'b0;
      allf_q <= 1'b0;
      acs_q  <= 1'b0;
      clm_q  <= 1'b0;
      disc_q <= 1'b0;
      fwd_q  <= 1'b0;
      log_q  <= 1'b0;
      cpl_q  <= 1'b0;
      cst_q  <= 3'h0;
      cfn_q  <= 3'h0;
      dpp_q  <= 1'b0;
      dps_q  <= 1'b0;
    end
    else
    begin
      corr_q <= corr_d;
      unf_q  <= unf_d;
      fat_q  <= fat_d;
      allf_q <= allf_d;
      acs_q  <= acs_d;
      clm_q  <= clm_d;
      disc_q <= disc_d;
      fwd_q  <= fwd_d;
      log_q  <= log_d;
      cpl_q  <= cpl_d;
      cst_q  <= cst_d;
      cfn_q  <= cfn_d;
      dpp_q  <= dpp_d;
      dps_q  <= dps_d;
    end
  end

  always_comb
  begin
    corr_err                 = corr_q;
    uncorr_nonfatal          = unf_q;
    uncorr_fatal             = fat_q;
    all_functions            = allf_q;
    acs_err                  = acs_q;
    tlp_claimed              = clm_q;
    tlp_discard              = disc_q;
    tlp_forward              = fwd_q;
    hdr_log                  = log_q;
    cpl_gen                  = cpl_q;
    cpl_status               = cst_q;
    cpl_func                 = cfn_q;
    parity_detected_flag_pri = dpp_q;
    parity_detected_flag_sec = dps_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_q);

  sequence s_link_fault;
    phy_link_err || phy_frame_err;
  endsequence

  link_corr_a: assert property (s_link_fault |=> corr_err && all_functions)
    else $error("link fault not correctable");

  bad_tlp_a: assert property (dll_bad_tlp && !phy_pkt_err && tlp_valid
                              |=> corr_err && tlp_discard && !tlp_forward)
    else $error("bad tlp not discarded");

  dup_supp_a: assert property (phy_pkt_err && tlp_valid && tlp_poisoned
                               |=> !hdr_log && !parity_detected_flag_pri
                                   || $past(parity_detected_flag_pri))
    else $error("error not suppressed");

  surprise_a: assert property (dll_surprise_down |=> uncorr_nonfatal || uncorr_fatal)
    else $error("link loss not uncorrectable");

  implicit_a: assert property (tlp_valid && tlp_route == pec_pkg::ROUTE_IMPLICIT
                               |=> tlp_claimed)
    else $error("implicit tlp not claimed");

  sec_claim_a: assert property (tlp_valid && tlp_secondary
                                && tlp_route != pec_pkg::ROUTE_IMPLICIT |=> tlp_claimed)
    else $error("secondary tlp not claimed");

  poison_side_a: assert property (tl_ok && tlp_poisoned && tlp_secondary
                                  |=> parity_detected_flag_sec && hdr_log)
    else $error("secondary parity flag missing");

  poison_fwd_a: assert property (poi_ev && !tlp_ultimate && !ur_ev && !acs_d
                                 |=> tlp_forward && !tlp_discard)
    else $error("poisoned tlp not forwarded");

  ur_cpl_a: assert property (ur_ev && tlp_non_posted && !acs_d
                             |=> cpl_gen && cpl_status == pec_pkg::CPL_UR)
    else $error("ur completion missing");

  acs_ca_a: assert property (cpl_gen && cpl_status == pec_pkg::CPL_CA |-> acs_err)
    else $error("completer abort without access error");

  poison_pri_a: assert property (poi_ev && !tlp_secondary |=> parity_detected_flag_pri)
    else $error("primary parity flag missing");

  dll_supp_a: assert property (phy_pkt_err && !dll_surprise_down
                               |=> !uncorr_nonfatal && !uncorr_fatal)
    else $error("link-layer error not suppressed");

  acs_drop_a: assert property (acs_d |=> acs_err && tlp_discard && !tlp_forward)
    else $error("access violation not dropped");

endmodule : pec_port_error_classifier

// [tb/pec_link_partner.sv]
/*
  Link partner model: turns one stimulus word into fault strobes and a TLP.
  Assumes the bench changes the word just after each core_clk edge.
*/
module pec_link_partner
(
  // Stimulus word
  input  wire logic [63:0]                stim,
  // Fault strobes
  output logic                            phy_link_err,
  output logic                            phy_frame_err,
  output logic                            phy_pkt_err,
  output logic                            dll_bad_tlp,
  output logic                            dll_bad_dllp,
  output logic                            dll_replay_tmo,
  output logic                            dll_replay_roll,
  output logic                            dll_ack_seq_err,
  output logic                            dll_surprise_down,
  // Received TLP
  output logic                            tlp_valid,
  output logic                            tlp_secondary,
  output pec_pkg::pec_route_t             tlp_route,
  output logic [pec_pkg::ADDR_W-1:0]      tlp_addr,
  output logic [pec_pkg::BDF_W-1:0]       tlp_dest_id,
  output logic                            tlp_from_link,
  output logic                            tlp_ultimate,
  output logic                            tlp_poisoned,
  output logic                            tlp_digest,
  output logic                            tlp_ecrc_bad,
  output logic                            tlp_unsupported,
  output logic                            tlp_non_posted,
  output logic                            tlp_acs_violation
);
  logic [3:0] ev;
  logic [2:0] kind;
  logic [7:0] bus;

  always_comb
  begin
    ev = stim[3:0];
    kind = stim[14:12];
    // A flagged packet always brings a link fault, so the class stays known
    phy_pkt_err = (ev == 4'h3) || (ev == 4'hA) || (ev == 4'hB);
    phy_link_err = (ev == 4'h1) || phy_pkt_err;
    phy_frame_err = (ev == 4'h2);
    dll_bad_tlp = (ev == 4'h4) || (ev == 4'hB);
    dll_bad_dllp = (ev == 4'h5);
    dll_replay_tmo = (ev == 4'h6);
    dll_replay_roll = (ev == 4'h7);
    dll_ack_seq_err = (ev == 4'h8) || (ev == 4'hA);
    dll_surprise_down = (ev == 4'h9);
    tlp_valid = stim[4];
    tlp_secondary = stim[5];
    tlp_route = (stim[7:6] == 2'h3) ? pec_pkg::ROUTE_IMPLICIT : pec_pkg::pec_route_t'(stim[7:6]);
    tlp_from_link = stim[8];
    tlp_ultimate = stim[9];
    tlp_non_posted = stim[10];
    tlp_digest = stim[11];
    // One fault kind per packet
    tlp_poisoned = (kind == 3'h1);
    tlp_ecrc_bad = (kind == 3'h2);
    tlp_unsupported = (kind == 3'h3);
    tlp_acs_violation = (kind == 3'h4);
    case (stim[17:15])
      3'h0: tlp_addr = 64'hFFF;
      3'h1: tlp_addr = 64'h1000;
      3'h2: tlp_addr = 64'h1FFF;
      3'h3: tlp_addr = 64'h2000;
      3'h4: tlp_addr = 64'h7FFF_FFFF;
      3'h5: tlp_addr = 64'h8000_0000;
      3'h6: tlp_addr = 64'h8000_FFFF;
      default: tlp_addr = 64'h8001_0000;
    endcase
    case (stim[19:18])
      2'h0: bus = 8'h0F;
      2'h1: bus = 8'h10;
      2'h2: bus = 8'h1F;
      default: bus = 8'h20;
    endcase
    tlp_dest_id = {bus, 4'h0, stim[23:20]};
  end
endmodule : pec_link_partner

// [tb/tb_pcie_port_error_classifier.sv]
/*
  Self-checking bench for the port error classifier, random traffic.
  Assumes one-cycle output latency and a two-flop reset release.
*/
module tb_pcie_port_error_classifier;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Signals
  // ------
  logic                core_clk, rstn, run, have, pri_f, sec_f;
  logic [63:0]         stim, win0_base, win0_limit, win1_base, win1_limit;
  logic                phy_link_err, phy_frame_err, phy_pkt_err, dll_bad_tlp, dll_bad_dllp;
  logic                dll_replay_tmo, dll_replay_roll, dll_ack_seq_err, dll_surprise_down;
  logic                tlp_valid, tlp_secondary, tlp_from_link, tlp_ultimate, tlp_poisoned;
  logic                tlp_digest, tlp_ecrc_bad, tlp_unsupported, tlp_non_posted, tlp_acs;
  pec_pkg::pec_route_t tlp_route;
  logic [63:0]         tlp_addr;
  logic [15:0]         tlp_dest_id, own_bdf;
  logic [7:0]          sec_bus, sub_bus;
  logic [5:0]          sev;
  logic [1:0]          ecrc_en;
  logic                corr_err, unc_nf, unc_f, all_functions, acs_err, tlp_claimed;
  logic                tlp_discard, tlp_forward, hdr_log, cpl_gen, pflag_pri, pflag_sec;
  logic [2:0]          cpl_status, cpl_func;
  logic [17:0]         got, exp_v, msk_v;
  logic [31:0]         xs_s;
  int                  error_cnt, n_checks;

  assign sev = stim[35:30];
  assign ecrc_en = stim[37:36];
  assign got = {corr_err, unc_nf, unc_f, all_functions, acs_err, tlp_claimed, tlp_discard,
                tlp_forward, hdr_log, cpl_gen, cpl_status, cpl_func, pflag_pri, pflag_sec};

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  pec_link_partner u_partner (.stim(stim), .phy_link_err(phy_link_err),
    .phy_frame_err(phy_frame_err), .phy_pkt_err(phy_pkt_err), .dll_bad_tlp(dll_bad_tlp),
    .dll_bad_dllp(dll_bad_dllp), .dll_replay_tmo(dll_replay_tmo),
    .dll_replay_roll(dll_replay_roll), .dll_ack_seq_err(dll_ack_seq_err),
    .dll_surprise_down(dll_surprise_down), .tlp_valid(tlp_valid), .tlp_secondary(tlp_secondary),
    .tlp_route(tlp_route), .tlp_addr(tlp_addr), .tlp_dest_id(tlp_dest_id),
    .tlp_from_link(tlp_from_link), .tlp_ultimate(tlp_ultimate), .tlp_poisoned(tlp_poisoned),
    .tlp_digest(tlp_digest), .tlp_ecrc_bad(tlp_ecrc_bad), .tlp_unsupported(tlp_unsupported),
    .tlp_non_posted(tlp_non_posted), .tlp_acs_violation(tlp_acs));

  pec_port_error_classifier #(.NUM_FUNC(2)) dut (.core_clk(core_clk), .rstn(rstn),
    .phy_link_err(phy_link_err), .phy_frame_err(phy_frame_err), .phy_pkt_err(phy_pkt_err),
    .dll_bad_tlp(dll_bad_tlp), .dll_bad_dllp(dll_bad_dllp), .dll_replay_tmo(dll_replay_tmo),
    .dll_replay_roll(dll_replay_roll), .dll_ack_seq_err(dll_ack_seq_err),
    .dll_surprise_down(dll_surprise_down), .tlp_valid(tlp_valid), .tlp_secondary(tlp_secondary),
    .tlp_route(tlp_route), .tlp_addr(tlp_addr), .tlp_dest_id(tlp_dest_id),
    .tlp_from_link(tlp_from_link), .tlp_ultimate(tlp_ultimate), .tlp_poisoned(tlp_poisoned),
    .tlp_digest(tlp_digest), .tlp_ecrc_bad(tlp_ecrc_bad), .tlp_unsupported(tlp_unsupported),
    .tlp_non_posted(tlp_non_posted), .tlp_acs_violation(tlp_acs), .func_ecrc_en(ecrc_en),
    .win0_base(win0_base), .win0_limit(win0_limit), .win1_base(win1_base),
    .win1_limit(win1_limit), .sec_bus(sec_bus), .sub_bus(sub_bus), .own_bdf(own_bdf),
    .uncorrectable_severity_register(sev), .parity_flag_clr_pri(&stim[40:38]),
    .parity_flag_clr_sec(&stim[43:41]), .corr_err(corr_err), .uncorr_nonfatal(unc_nf),
    .uncorr_fatal(unc_f), .all_functions(all_functions), .acs_err(acs_err),
    .tlp_claimed(tlp_claimed), .tlp_discard(tlp_discard), .tlp_forward(tlp_forward),
    .hdr_log(hdr_log), .cpl_gen(cpl_gen), .cpl_status(cpl_status), .cpl_func(cpl_func),
    .parity_detected_flag_pri(pflag_pri), .parity_detected_flag_sec(pflag_sec));

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xs();
    xs_s = xs_s ^ (xs_s << 13);
    xs_s = xs_s ^ (xs_s >> 17);
    xs_s = xs_s ^ (xs_s << 5);
    return xs_s;
  endfunction : xs

  task automatic chk(input logic [17:0] g, input logic [17:0] e, input logic [17:0] m);
    n_checks++;
    if ((g & m) !== (e & m))
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ------
  // Reference model, one cycle ahead of the outputs
  // ------
  always @(negedge core_clk)
  begin
    logic [17:0] x;
    logic [17:0] m;
    logic        adv, sp, ss, ult;
    logic [7:0]  bus;
    int          k;
    if (run)
    begin
      if (have)
      begin
        chk(got, exp_v, msk_v & 18'h3E000);
        chk(got, exp_v, msk_v & 18'h01FFC);
        chk(got, exp_v, msk_v & 18'h00003);
      end
      x = '0;
      m = 18'h3E303;
      ult = tlp_ultimate;
      adv = 1'b0;
      sp = 1'b0;
      ss = 1'b0;
      k = 0;
      if (phy_link_err || phy_frame_err || dll_replay_tmo || dll_replay_roll)
        x[17] = 1'b1;
      if (dll_surprise_down)
        x[sev[1] ? 15 : 16] = 1'b1;
      if (!phy_pkt_err)
      begin
        if (dll_bad_tlp || dll_bad_dllp)
          x[17] = 1'b1;
        if (dll_ack_seq_err)
          x[sev[0] ? 15 : 16] = 1'b1;
        if (dll_bad_tlp && tlp_valid)
        begin
          x[11] = 1'b1;
          m = m | 18'h00C00;
        end
      end
      x[14] = x[17] | x[16] | x[15];
      // Lower-layer faults hide every packet-level consequence except the bad-TLP discard
      if (tlp_valid && !phy_pkt_err && !dll_bad_tlp)
      begin
        bus = tlp_dest_id[15:8];
        case (tlp_route)
          pec_pkg::ROUTE_ADDR: x[12] = tlp_secondary
            || (tlp_addr >= win0_base && tlp_addr <= win0_limit)
            || (tlp_addr >= win1_base && tlp_addr <= win1_limit);
          pec_pkg::ROUTE_ID: x[12] = tlp_secondary
            || (bus >= sec_bus && bus <= sub_bus) || (tlp_dest_id == own_bdf);
          default: x[12] = 1'b1;
        endcase
        m[12] = 1'b1;
        if (tlp_poisoned)
        begin
          k = 2;
          adv = tlp_from_link || ult;
          sp = !tlp_secondary;
          ss = tlp_secondary;
        end
        else if (tlp_ecrc_bad && tlp_digest && (|ecrc_en))
        begin
          k = 3;
          adv = tlp_from_link && !ult;
        end
        else if (tlp_unsupported)
        begin
          k = 4;
          adv = tlp_non_posted;
          x[8] = tlp_non_posted;
          x[7:5] = pec_pkg::CPL_UR;
          x[4:2] = pec_pkg::FUNC_ZERO;
          x[11] = 1'b1;
          m = m | 18'h00C00 | (tlp_non_posted ? 18'h000FC : 18'h0);
        end
        else if (tlp_acs)
        begin
          x[13] = 1'b1;
          x[11] = 1'b1;
          x[8] = 1'b1;
          x[7:5] = pec_pkg::CPL_CA;
          x[4:2] = pec_pkg::FUNC_ZERO;
          m = (m | 18'h00DFC) & ~18'h00200;
        end
        if (k != 0)
        begin
          adv = adv && !sev[k];
          x[adv ? 17 : (sev[k] ? 15 : 16)] = 1'b1;
          x[9] = 1'b1;
          if (k < 4)
          begin
            x[11] = ult;
            x[10] = !ult;
            m = m | 18'h00C00;
          end
        end
      end
      // Set wins over a clear in the same cycle
      pri_f = (pri_f && !(&stim[40:38])) || sp;
      sec_f = (sec_f && !(&stim[43:41])) || ss;
      x[1] = pri_f;
      x[0] = sec_f;
      exp_v = x;
      msk_v = m;
      have = 1'b1;
    end
  end

  // ------
  // Sequence
  // ------
  initial
  begin
    rstn = 1'b0;
    run = 1'b0;
    have = 1'b0;
    stim = '0;
    xs_s = 32'h0000_0021;
    pri_f = 1'b0;
    sec_f = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    win0_base = 64'h1000;
    win0_limit = 64'h1FFF;
    win1_base = 64'h8000_0000;
    win1_limit = 64'h8000_FFFF;
    sec_bus = 8'h10;
    sub_bus = 8'h1F;
    own_bdf = 16'h0F05;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    run <= 1'b1;
    repeat (6000) @(posedge core_clk) stim <= {xs(), xs()};
    @(posedge core_clk) stim <= '0;
    repeat (3) @(posedge core_clk);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_pcie_port_error_classifier
